/* File: hw/io_bus_response.sv */
// Behaviour
// RL1: Sync answer depends on control lines, delayed attention and addressed section.
// RL2: Address match with strobe raises internal sync pulse.
// RL3: Sync pulse passes two register stages before the sync line.
// RL4: Micro-handled control ops raise bus-request interrupt, no immediate sync.
// RL5: Micro completion sets flip-flop that drives sync via two stages.
// RL6: Host drops control after sync; micro sync cleared by sync reset.
// RL7: Selects 00 route internal byte; low byte driven only with enable.
// RL8: Selects 01 route assist byte; high-byte enable gates upper byte.
// RL9: Selects 10 return switch nibble over latched line nibble.
// RL10: Selects 11 return 6C if interval clock wins, else 6D.
// RL11: Acknowledge decoder clears channel, interval, line or printer by code.
// RL12: Data bits 6 and 7 form top of every device address compare.
// RL13: Bus-in strobe captures bus byte into buffered micro byte.
// RL14: Bus-out strobe loads micro byte onto internal output bus.
// RL15: Loader recognised at address 05 when enabled.
// RL16: Loader flag latched on full match, held till another address.
// RL17: Strap or bootstrap disable forces loader flag input low.
// RL18: Selected loader raises level 2 interrupt on request, data or command.
// RL19: Encoded level latched and driven to micro priority inputs.
// RL20: Function code all ones gives acknowledge; loader level yields autovector.
// RL21: Loader data request: output register, selects 00, enable, delayed sync.
// RL22: Attention held while pending; acknowledge trapped, not passed on.
// RL23: Priority: assist, channels, interval clock, line clock, printer.
// RL24: Acknowledge freezes latch; attention sync registered twice first.
// RL25: Sync, output enable and drivers release when control drops.
// RL26: System clear resets sync stages, loader flag and interrupt latch.
`default_nettype none
module io_bus_response
  import bus_resp_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire bus_resp_pkg::bus_ctl_t i_bus_ctl,
  input wire logic [7:0] i_bus_in_byte,
  input wire logic [7:0] i_dev_addr,
  input wire logic i_multi_io_board_sel,
  input wire bus_resp_pkg::attn_req_t i_attn_req,
  input wire logic [3:0] i_irq_line_nibble,
  input wire logic [3:0] i_switch_high_nibble,
  input wire logic [7:0] i_assist_data_byte,
  input wire logic i_loader_strap_n,
  input wire logic i_loader_boot_enable,
  input wire logic i_micro_done,
  input wire logic i_bus_out_strobe_n,
  input wire logic [7:0] i_micro_out_byte,
  input wire logic [2:0] i_micro_fc,
  input wire logic [2:0] i_micro_addr_level,
  output logic o_sync_resp_n,
  output logic o_attention_n,
  output logic o_int_ack_out_n,
  output logic [7:0] o_bus_out_byte,
  output logic o_bus_low_byte_oe_n,
  output logic o_assist_high_byte_oe_n,
  output logic o_bus_request_irq_n,
  output logic o_micro_sync_reset,
  output logic [7:0] o_buffered_micro_byte,
  output logic [2:0] o_micro_ipl,
  output logic o_micro_irq_ack,
  output logic o_autovector_req_n,
  output logic o_loader_selected_n,
  output bus_resp_pkg::ack_clear_t o_ack_clear
);
  import bus_resp_pkg::*;

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  // Every bus pin is asynchronous to the board clock.
  bus_ctl_t ctl_s1_q, ctl_q;
  attn_req_t attn_s1_q, attn_q;
  logic [7:0] din_s1_q, din_q;
  logic [7:0] daddr_s1_q, daddr_q;
  logic strap_s1_q, strap_q, boot_s1_q, boot_q;
  logic sel_s1_q, sel_q;
  always_ff @(posedge i_clk) begin
    ctl_s1_q <= i_bus_ctl;
    ctl_q <= ctl_s1_q;
    attn_s1_q <= i_attn_req;
    attn_q <= attn_s1_q;
    din_s1_q <= i_bus_in_byte;
    din_q <= din_s1_q;
    daddr_s1_q <= i_dev_addr;
    daddr_q <= daddr_s1_q;
    strap_s1_q <= i_loader_strap_n;
    strap_q <= strap_s1_q;
    boot_s1_q <= i_loader_boot_enable;
    boot_q <= boot_s1_q;
    sel_s1_q <= i_multi_io_board_sel;
    sel_q <= sel_s1_q;
  end

  logic ctl_active, ctl_active_q, out_op, in_op, micro_op;
  logic addr_match;
  // Any control line still active holds the current operation
  assign ctl_active = !ctl_q.addr_strobe_n || !ctl_q.status_req_n ||
    !ctl_q.command_strobe_n || !ctl_q.data_req_n ||
    !ctl_q.data_avail_n || !ctl_q.int_ack_in_n;
  assign out_op = !ctl_q.command_strobe_n || !ctl_q.data_avail_n;
  assign in_op = !ctl_q.data_req_n;
  // Upper two address bits taken from the bus byte itself
  assign addr_match = (din_q[7:6] == daddr_q[7:6]) &&
    (din_q[5:0] == daddr_q[5:0]); // RL12

  // ----------------------------------------------------------------
  // Section addressing
  // ----------------------------------------------------------------
  // Loader flag holds until a different address is strobed.
  logic loader_sel_q, board_sel_q, loader_en;
  assign loader_en = strap_q && boot_q; // RL17
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      loader_sel_q <= 1'b0; // RL26
      board_sel_q <= 1'b0;
    end else if (!ctl_q.addr_strobe_n && ctl_active_q == 1'b0) begin
      loader_sel_q <= loader_en && (din_q == LOADER_ADDR); // RL15 RL16
      board_sel_q <= sel_q && addr_match;
    end
  end
  assign micro_op = board_sel_q && !loader_sel_q && (out_op || in_op);

  // ----------------------------------------------------------------
  // Attention priority and acknowledge
  // ----------------------------------------------------------------
  logic [2:0] pri_d, pri_q;
  logic atsync_s1_q, atsync_q;
  // Encoder; assist has no external attention
  always_comb begin
    if (!attn_q.assist_priority_n) pri_d = PRI_ASSIST; // RL23
    else if (!attn_q.channel_attention_n) pri_d = PRI_CHANNEL;
    else if (!attn_q.interval_clk_attn_n) pri_d = PRI_INTERVAL;
    else if (!attn_q.line_clk_attn_n) pri_d = PRI_LINE;
    else if (!attn_q.printer_attn_n) pri_d = PRI_PRINTER;
    else pri_d = PRI_NONE;
  end

  // Latch is transparent until an acknowledge freezes it
  always_ff @(posedge i_clk) begin
    if (i_rst) pri_q <= PRI_NONE;
    else if (ctl_q.int_ack_in_n) pri_q <= pri_d; // RL24
  end

  // Attention sync ranked twice before it enables the decoder
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      atsync_s1_q <= 1'b0;
      atsync_q <= 1'b0;
    end else begin
      atsync_s1_q <= !ctl_q.int_ack_in_n; // RL24
      atsync_q <= atsync_s1_q;
    end
  end

  logic pending, ack_seen_q;
  assign pending = (pri_q != PRI_NONE) && (pri_q != PRI_ASSIST);
  // Attention, trap and one-shot clears per acknowledge
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_attention_n <= 1'b1;
      o_int_ack_out_n <= 1'b1;
      o_ack_clear <= '1;
      ack_seen_q <= 1'b0;
    end else begin
      o_attention_n <= !pending; // RL22
      o_int_ack_out_n <= ctl_q.int_ack_in_n || pending; // RL22
      ack_seen_q <= atsync_q;
      o_ack_clear <= '1;
      if (atsync_q && !ack_seen_q) begin
        unique case (pri_q) // RL11
          PRI_CHANNEL: o_ack_clear.clr_channel_n <= 1'b0;
          PRI_INTERVAL: o_ack_clear.clear_interval_clk_n <= 1'b0;
          PRI_LINE: o_ack_clear.clr_line_clk_n <= 1'b0;
          PRI_PRINTER: o_ack_clear.clr_printer_n <= 1'b0;
          default: o_ack_clear <= '1;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Sync generation and output routing
  // ----------------------------------------------------------------
  logic pulse_d, pulse_s1_q, pulse_s2_q, micro_sync_q;
  logic [1:0] sel_d;
  logic low_oe_d, high_oe_d, irq_d, ack_own;
  assign ack_own = atsync_q && pending;
  // Decision logic: which sync and which source
  always_comb begin
    pulse_d = 1'b0;
    sel_d = SEL_INTERNAL;
    low_oe_d = 1'b0;
    high_oe_d = 1'b0;
    irq_d = 1'b0;
    if (!ctl_q.addr_strobe_n && sel_q && addr_match) begin
      pulse_d = 1'b1; // RL2
    end else if (!ctl_q.addr_strobe_n && loader_en &&
                 din_q == LOADER_ADDR) begin
      pulse_d = 1'b1; // RL15
    end else if (ack_own) begin
      pulse_d = 1'b1; // RL1
      low_oe_d = 1'b1;
      unique case (pri_q)
        PRI_CHANNEL: sel_d = SEL_CHANNEL; // RL9
        PRI_INTERVAL, PRI_LINE: sel_d = SEL_CLOCKS; // RL10
        default: sel_d = SEL_INTERNAL;
      endcase
    end else if (loader_sel_q && in_op) begin
      pulse_d = 1'b1; // RL21
      low_oe_d = 1'b1;
    end else if (board_sel_q && !ctl_q.status_req_n) begin
      pulse_d = 1'b1; // RL1
      low_oe_d = 1'b1;
      sel_d = SEL_ASSIST; // RL8
      high_oe_d = 1'b1;
    end else if (micro_op) begin
      irq_d = 1'b1; // RL4
      low_oe_d = in_op;
    end
  end

  // Micro completion flag, cleared after the host releases control
  always_ff @(posedge i_clk) begin
    if (i_rst) micro_sync_q <= 1'b0;
    else if (i_micro_done) micro_sync_q <= 1'b1; // RL5
    else if (!ctl_active) micro_sync_q <= 1'b0; // RL6
  end

  // Two-stage sync ranking; drops when control drops
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      pulse_s1_q <= 1'b0;
      pulse_s2_q <= 1'b0;
      o_sync_resp_n <= 1'b1;
    end else begin
      pulse_s1_q <= (pulse_d || micro_sync_q) && ctl_active; // RL3 RL25
      pulse_s2_q <= pulse_s1_q && ctl_active;
      o_sync_resp_n <= !(pulse_s2_q && ctl_active); // RL3
    end
  end

  // Bus-request interrupt, enables, sync reset
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_bus_request_irq_n <= 1'b1;
      o_bus_low_byte_oe_n <= 1'b1;
      o_assist_high_byte_oe_n <= 1'b1;
      o_micro_sync_reset <= 1'b0;
      ctl_active_q <= 1'b0;
    end else begin
      o_bus_request_irq_n <= !(irq_d && !micro_sync_q); // RL4
      o_bus_low_byte_oe_n <= !(low_oe_d && ctl_active); // RL7 RL25
      o_assist_high_byte_oe_n <= !high_oe_d; // RL8
      o_micro_sync_reset <= micro_sync_q && !ctl_active; // RL6
      ctl_active_q <= ctl_active;
    end
  end

  // ----------------------------------------------------------------
  // Data path registers
  // ----------------------------------------------------------------
  logic [7:0] internal_out_bus_q;
  logic bin_s1_q, bin_q, bin_prev_q, bout_s1_q, bout_q, bout_prev_q;
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      bin_s1_q <= 1'b1;
      bin_q <= 1'b1;
      bin_prev_q <= 1'b1;
    end else begin
      bin_s1_q <= ctl_q.command_strobe_n && ctl_q.data_avail_n;
      bin_q <= bin_s1_q;
      bin_prev_q <= bin_q;
    end
  end
  // Bus-in capture on the falling edge of the in-strobe
  always_ff @(posedge i_clk) begin
    if (i_rst) o_buffered_micro_byte <= 8'h00;
    else if (!bin_q && bin_prev_q && micro_op)
      o_buffered_micro_byte <= din_q; // RL13
  end
  // Bus-out strobe comes from the micro domain, ranked twice before its edge is taken
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      bout_s1_q <= 1'b1;
      bout_q <= 1'b1;
      bout_prev_q <= 1'b1;
      internal_out_bus_q <= 8'h00;
    end else begin
      bout_s1_q <= i_bus_out_strobe_n;
      bout_q <= bout_s1_q;
      bout_prev_q <= bout_q;
      if (!bout_q && bout_prev_q)
        internal_out_bus_q <= i_micro_out_byte; // RL14 RL21
    end
  end

  // Four-way output selector; zeros while not enabled
  always_ff @(posedge i_clk) begin
    if (i_rst) o_bus_out_byte <= 8'h00;
    else if (!(low_oe_d && ctl_active)) o_bus_out_byte <= 8'h00; // RL25
    else begin
      unique case (sel_d)
        SEL_INTERNAL: o_bus_out_byte <= internal_out_bus_q; // RL7
        SEL_ASSIST: o_bus_out_byte <= i_assist_data_byte; // RL8
        SEL_CHANNEL:
          o_bus_out_byte <= {i_switch_high_nibble,
                             i_irq_line_nibble}; // RL9
        SEL_CLOCKS:
          o_bus_out_byte <= (pri_q == PRI_INTERVAL) ?
            INTERVAL_CLK_VEC : LINE_CLK_VEC; // RL10
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Microprocessor interrupt latch and acknowledge
  // ----------------------------------------------------------------
  logic loader_irq;
  assign loader_irq = loader_sel_q && (in_op || out_op); // RL18
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_micro_ipl <= IPL_NONE; // RL26
      o_micro_irq_ack <= 1'b0;
      o_autovector_req_n <= 1'b1;
      o_loader_selected_n <= 1'b1;
    end else begin
      if (irq_d && !micro_sync_q) o_micro_ipl <= IPL_BUS_REQ; // RL19
      else if (loader_irq) o_micro_ipl <= IPL_LOADER; // RL18 RL19
      else o_micro_ipl <= IPL_NONE;
      o_micro_irq_ack <= (i_micro_fc == FC_IACK); // RL20
      o_autovector_req_n <= !(i_micro_fc == FC_IACK &&
        i_micro_addr_level == IPL_LOADER); // RL20
      o_loader_selected_n <= !loader_sel_q;
    end
  end
endmodule
`default_nettype wire

/* File: shared/bus_resp_pkg.sv */
`default_nettype none
package bus_resp_pkg;
  // Output selector codes {select_b, select_a}
  localparam logic [1:0] SEL_INTERNAL = 2'h0;
  localparam logic [1:0] SEL_ASSIST = 2'h1;
  localparam logic [1:0] SEL_CHANNEL = 2'h2;
  localparam logic [1:0] SEL_CLOCKS = 2'h3;
  // Fixed addresses
  localparam logic [7:0] LOADER_ADDR = 8'h05;
  localparam logic [7:0] INTERVAL_CLK_VEC = 8'h6C;
  localparam logic [7:0] LINE_CLK_VEC = 8'h6D;
  // Acknowledge decoder priority codes
  localparam logic [2:0] PRI_ASSIST = 3'h0;
  localparam logic [2:0] PRI_CHANNEL = 3'h1;
  localparam logic [2:0] PRI_INTERVAL = 3'h2;
  localparam logic [2:0] PRI_LINE = 3'h3;
  localparam logic [2:0] PRI_PRINTER = 3'h4;
  localparam logic [2:0] PRI_NONE = 3'h7;
  // Microprocessor interrupt levels
  localparam logic [2:0] IPL_NONE = 3'h0;
  localparam logic [2:0] IPL_LOADER = 3'h2;
  localparam logic [2:0] IPL_BUS_REQ = 3'h4;
  localparam logic [2:0] FC_IACK = 3'h7;

  // Bus control lines, active low, as seen at the board
  typedef struct packed {
    logic addr_strobe_n;
    logic status_req_n;
    logic command_strobe_n;
    logic data_req_n;
    logic data_avail_n;
    logic int_ack_in_n;
  } bus_ctl_t;

  // Internal attention requests, active low
  typedef struct packed {
    logic assist_priority_n;
    logic channel_attention_n;
    logic interval_clk_attn_n;
    logic line_clk_attn_n;
    logic printer_attn_n;
  } attn_req_t;

  // Acknowledge clears, active low, one-cycle pulses
  typedef struct packed {
    logic clr_channel_n;
    logic clear_interval_clk_n;
    logic clr_line_clk_n;
    logic clr_printer_n;
  } ack_clear_t;
endpackage
`default_nettype wire

/* File: test/io_bus_response_props.sv */
`default_nettype none
module io_bus_response_props
  import bus_resp_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire bus_resp_pkg::bus_ctl_t i_bus_ctl,
  input wire logic [7:0] i_bus_in_byte,
  input wire logic i_loader_strap_n,
  input wire logic i_loader_boot_enable,
  input wire logic [2:0] i_micro_fc,
  input wire logic [2:0] i_micro_addr_level,
  input wire logic o_sync_resp_n,
  input wire logic o_attention_n,
  input wire logic o_int_ack_out_n,
  input wire logic o_bus_low_byte_oe_n,
  input wire logic [2:0] o_micro_ipl,
  input wire logic o_autovector_req_n,
  input wire logic o_loader_selected_n,
  input wire bus_resp_pkg::ack_clear_t o_ack_clear
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----
  // Bus answer checks
  // ----
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // Six quiet cycles give the release path time to drain
  sequence s_ctl_idle;
    (&i_bus_ctl) [*6];
  endsequence
  sequence s_loader_addr;
    $fell(i_bus_ctl.addr_strobe_n) && i_bus_in_byte == LOADER_ADDR &&
      i_loader_strap_n && i_loader_boot_enable;
  endsequence
  a_loader_addr_sync: assert property (
    s_loader_addr |-> ##[3:6] (!o_sync_resp_n && !o_loader_selected_n))
    else $error("loader address not answered");
  a_sync_two_rank: assert property (
    $fell(i_bus_ctl.addr_strobe_n) |-> o_sync_resp_n [*3])
    else $error("sync came before the two ranks");
  a_sync_release: assert property (s_ctl_idle |-> o_sync_resp_n)
    else $error("sync held with control idle");
  a_oe_release: assert property (s_ctl_idle |-> o_bus_low_byte_oe_n)
    else $error("low byte driven with control idle");
  a_loader_level: assert property (
    !o_loader_selected_n && $fell(i_bus_ctl.data_req_n) |->
      ##[2:8] o_micro_ipl == IPL_LOADER)
    else $error("loader level not presented");
  a_autovector_ack: assert property (
    i_micro_fc == FC_IACK && i_micro_addr_level == IPL_LOADER |->
      ##[0:2] !o_autovector_req_n)
    else $error("no autovector for loader level");
  a_single_clear: assert property ($onehot0(~o_ack_clear))
    else $error("more than one clear at once");
  a_ack_trapped: assert property (
    $fell(i_bus_ctl.int_ack_in_n) && !o_attention_n |->
      o_int_ack_out_n [*4])
    else $error("acknowledge passed on while pending");
  a_reset_idle: assert property (
    $fell(i_rst) |-> o_sync_resp_n && o_loader_selected_n &&
      o_micro_ipl == IPL_NONE)
    else $error("outputs not idle after reset");
endmodule
bind io_bus_response io_bus_response_props PROPS (
  .i_clk(i_clk), .i_rst(i_rst), .i_bus_ctl(i_bus_ctl),
  .i_bus_in_byte(i_bus_in_byte), .i_loader_strap_n(i_loader_strap_n),
  .i_loader_boot_enable(i_loader_boot_enable), .i_micro_fc(i_micro_fc),
  .i_micro_addr_level(i_micro_addr_level),
  .o_sync_resp_n(o_sync_resp_n), .o_attention_n(o_attention_n),
  .o_int_ack_out_n(o_int_ack_out_n),
  .o_bus_low_byte_oe_n(o_bus_low_byte_oe_n), .o_micro_ipl(o_micro_ipl),
  .o_autovector_req_n(o_autovector_req_n),
  .o_loader_selected_n(o_loader_selected_n), .o_ack_clear(o_ack_clear));
`default_nettype wire

/* File: test/mux_host_model.sv */
`default_nettype none
module mux_host_model
  import bus_resp_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_sync_resp_n,
  input wire logic i_oe_n,
  input wire logic [7:0] i_out_byte,
  output bus_resp_pkg::bus_ctl_t o_bus_ctl,
  output logic [7:0] o_bus_byte
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    o_bus_ctl = '1;
    o_bus_byte = 8'h00;
  end
  // Data first, then the line; answer taken on the sync edge itself
  task automatic op(input int idx, input logic [7:0] b, input int lim,
                    output logic seen, output logic [7:0] got,
                    output logic oe_n);
    int n;
    seen = 1'h0;
    got = 8'h00;
    oe_n = 1'h1;
    o_bus_byte = b;
    @(posedge i_clk);
    #1;
    o_bus_ctl[idx] = 1'h0;
    for (n = 0; n < lim && !seen; n++) begin
      @(posedge i_clk);
      seen = (i_sync_resp_n === 1'h0);
      got = i_out_byte;
      oe_n = i_oe_n;
    end
    #1;
    o_bus_ctl[idx] = 1'h1;
    o_bus_byte = ~b; // Released lines must not hold a stale value
    repeat (8) @(posedge i_clk);
    #1;
  endtask
endmodule
`default_nettype wire

/* File: test/io_bus_response_tb.sv */
`default_nettype none
module io_bus_response_tb;
  import bus_resp_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int AS = 5;
  localparam int SR = 4;
  localparam int CMD = 3;
  localparam int DR = 2;
  localparam int ACK = 0;
  logic i_clk = 1'h0;
  logic i_rst = 1'h1;
  bus_ctl_t ctl;
  attn_req_t attn = '1;
  ack_clear_t clr;
  logic [7:0] hbyte, obyte, mbb, got, mob = 8'h00;
  logic board_sel = 1'h0, strap_n = 1'h1, boot_en = 1'h1, done = 1'h0;
  logic bos_n = 1'h1, msr_seen = 1'h0, seen, goe_n;
  logic [2:0] fc = 3'h0, lvl = 3'h0, ipl;
  logic sync_n, attn_n, ackout_n, oe_n, hoe_n, breq_n, msr, iack;
  logic av_n, lsel_n;
  logic [3:0] clr_seen = 4'h0;
  int failures = 0;
  int checked = 0;
  io_bus_response DUT (.i_clk(i_clk), .i_rst(i_rst), .i_bus_ctl(ctl),
    .i_bus_in_byte(hbyte), .i_dev_addr(8'h30),
    .i_multi_io_board_sel(board_sel), .i_attn_req(attn),
    .i_irq_line_nibble(4'h3), .i_switch_high_nibble(4'h9),
    .i_assist_data_byte(8'h5A), .i_loader_strap_n(strap_n),
    .i_loader_boot_enable(boot_en), .i_micro_done(done),
    .i_bus_out_strobe_n(bos_n), .i_micro_out_byte(mob), .i_micro_fc(fc),
    .i_micro_addr_level(lvl), .o_sync_resp_n(sync_n),
    .o_attention_n(attn_n), .o_int_ack_out_n(ackout_n),
    .o_bus_out_byte(obyte), .o_bus_low_byte_oe_n(oe_n),
    .o_assist_high_byte_oe_n(hoe_n), .o_bus_request_irq_n(breq_n),
    .o_micro_sync_reset(msr), .o_buffered_micro_byte(mbb),
    .o_micro_ipl(ipl), .o_micro_irq_ack(iack),
    .o_autovector_req_n(av_n), .o_loader_selected_n(lsel_n),
    .o_ack_clear(clr));
  mux_host_model HOST (.i_clk(i_clk), .i_sync_resp_n(sync_n),
    .i_oe_n(oe_n), .i_out_byte(obyte), .o_bus_ctl(ctl), .o_bus_byte(hbyte));
  // ----
  // Clock, pulse catchers, checks
  // ----
  always #2 i_clk = ~i_clk;
  // Clears and sync resets last one cycle, so they are caught here
  always @(posedge i_clk) begin
    clr_seen <= clr_seen | ~clr;
    if (msr) msr_seen <= 1'h1;
  end
  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    checked++;
    if (g !== e) begin
      failures++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic chk1(input logic g, input logic e);
    chk8({7'h00, g}, {7'h00, e});
  endtask
  task automatic conclude();
    $display("checked=%0d failures=%0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // ----
  // Scenarios
  // ----
  task automatic t_loader();
    mob = 8'hA5;
    bos_n = 1'h0;
    repeat (2) @(posedge i_clk);
    #1;
    bos_n = 1'h1;
    HOST.op(AS, LOADER_ADDR, 20, seen, got, goe_n);
    chk1(seen, 1'h1);
    chk1(lsel_n, 1'h0);
    HOST.op(DR, 8'h00, 20, seen, got, goe_n);
    chk8(got, 8'hA5);
    chk1(goe_n, 1'h0);
    chk1(oe_n, 1'h1);
    fc = FC_IACK;
    lvl = IPL_LOADER;
    repeat (3) @(posedge i_clk);
    #1;
    chk1(av_n, 1'h0);
    chk1(iack, 1'h1);
    fc = 3'h0;
  endtask
  // A zero expected byte means only the clear is judged
  task automatic t_ack(input attn_req_t a, input logic [7:0] eb,
                       input logic [3:0] em);
    attn = a;
    repeat (6) @(posedge i_clk);
    #1;
    chk1(attn_n, 1'h0);
    clr_seen = 4'h0;
    HOST.op(ACK, 8'h00, 30, seen, got, goe_n);
    if (eb != 8'h00) chk8(got, eb);
    chk8({4'h0, clr_seen}, {4'h0, em});
    attn = '1;
  endtask
  // Nothing pending: the acknowledge must travel on down the chain
  task automatic t_ack_pass();
    attn = '1;
    repeat (6) @(posedge i_clk);
    #1;
    chk1(attn_n, 1'h1);
    clr_seen = 4'h0;
    fork
      HOST.op(ACK, 8'h00, 10, seen, got, goe_n);
      begin
        repeat (5) @(posedge i_clk);
        #1;
        chk1(ackout_n, 1'h0);
      end
    join
    chk1(seen, 1'h0);
    chk8({4'h0, clr_seen}, 8'h00);
  endtask
  // Upper address bits differ only, so the board must stay silent
  task automatic t_micro();
    board_sel = 1'h1;
    HOST.op(AS, 8'hF0, 10, seen, got, goe_n);
    chk1(seen, 1'h0);
    HOST.op(AS, 8'h30, 20, seen, got, goe_n);
    chk1(seen, 1'h1);
    msr_seen = 1'h0;
    fork
      HOST.op(CMD, 8'hC3, 60, seen, got, goe_n);
      begin
        repeat (12) @(posedge i_clk);
        #1;
        chk1(sync_n, 1'h1);
        chk1(breq_n, 1'h0);
        done = 1'h1;
        @(posedge i_clk);
        #1;
        done = 1'h0;
      end
    join
    chk1(seen, 1'h1);
    chk1(msr_seen, 1'h1);
    chk8(mbb, 8'hC3);
    // Status request goes out through the assist path
    fork
      HOST.op(SR, 8'h00, 20, seen, got, goe_n);
      begin
        repeat (5) @(posedge i_clk);
        #1;
        chk1(hoe_n, 1'h0);
      end
    join
    chk1(seen, 1'h1);
    chk8(got, 8'h5A);
    chk1(goe_n, 1'h0);
    chk1(hoe_n, 1'h1);
    board_sel = 1'h0;
  endtask
  initial begin
    repeat (20000) @(posedge i_clk);
    failures++;
    conclude();
  end
  initial begin
    repeat (12) @(posedge i_clk);
    #1;
    i_rst = 1'h0;
    repeat (3) @(posedge i_clk);
    #1;
    chk1(sync_n, 1'h1);
    chk1(lsel_n, 1'h1);
    chk8({5'h00, ipl}, 8'h00);
    t_loader();
    HOST.op(AS, 8'h44, 10, seen, got, goe_n);
    chk1(lsel_n, 1'h1);
    strap_n = 1'h0;
    HOST.op(AS, LOADER_ADDR, 10, seen, got, goe_n);
    chk1(lsel_n, 1'h1);
    strap_n = 1'h1;
    boot_en = 1'h0;
    HOST.op(AS, LOADER_ADDR, 10, seen, got, goe_n);
    chk1(lsel_n, 1'h1);
    boot_en = 1'h1;
    t_ack(5'h1B, INTERVAL_CLK_VEC, 4'h4);
    t_ack(5'h1D, LINE_CLK_VEC, 4'h2);
    t_ack(5'h19, INTERVAL_CLK_VEC, 4'h4);
    t_ack(5'h17, 8'h93, 4'h8);
    t_ack(5'h1E, 8'h00, 4'h1);
    t_ack_pass();
    t_micro();
    conclude();
  end
endmodule
`default_nettype wire
